//--- verilog/lnmon_monitor.sv
// Error, sync request and link establishment monitor for the receiver.
`timescale 1ns/10ps
// Operation
// - A lane error in ST_LINK_UP that starts no resync pulses the sync request low for the programmed width.
// - Pulse length field bits 7..4 of 0x312: 0, 1, 2 select width.
// - Over-threshold events set status bits 7..5 when enabled in 0x4B8.
// - Four invalid-disparity characters on a lane force a link resync.
// - A resync holds the sync request low five frames plus nine octets.
// - Per-lane enables in bits 5..3 of 0x480..0x487, set at reset.
// - Selected error type reaching threshold on any lane drives sync low.
// - One error limit at 0x47C serves all lanes and types.
// - Resync clears all error counters but leaves interrupt status alone.
// - 0x470 bit x shows lane x passed code group sync.
// - 0x471 bit x shows lane x finished frame sync.
// - 0x472 bit x shows lane checksum matches the field sum.
// - With 0x300 bit 6 set, checksum sums bytes 0x400..0x40C plus lane id.
// - 0x473 bit x shows lane x passed lane alignment.
// - CGS, frame, checksum, alignment failures set status bits 0..3 when enabled in 0x4B8.
// - Writing one to a status bit of 0x4BA clears it.
// - Mismatch enable 0x4B9 bit 0, set at reset; status clears at 0x4BB.
// - Mismatch when configured 0x450..0x45D differ from received 0x400..
// - Each counter saturates at 0xFF or wraps per its hold bit.
// - Error limit resets to 0xFF and sync select to all types.
// - Writing zero to a lane counter reset bit clears that counter.
module lnmon_monitor #(
  parameter int NL = lnmon_pkg::NUM_LANES
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Register port
  input  wire logic [11:0]     reg_addr,
  input  wire logic            reg_wr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  // Lane decoder errors, one-cycle pulses
  input  wire logic [NL-1:0]   unexpected_control_char_error,
  input  wire logic [NL-1:0]   not_in_table_error,
  input  wire logic [NL-1:0]   bad_disparity_error,
  // Lane link establishment
  input  wire logic [NL-1:0]   lane_cgs_done,
  input  wire logic [NL-1:0]   lane_frame_done,
  input  wire logic [NL-1:0]   lane_ilas_done,
  input  wire logic [NL*8-1:0] lane_rx_checksum,
  input  wire logic [NL*5-1:0] lane_rx_id,
  input  wire logic [111:0]    rx_params,
  // Link
  output logic                 sync_request_out_n
);
  localparam int NT = lnmon_pkg::NUM_TYPES;
  localparam int NC = NL * NT;

  function automatic logic in_win(input logic [11:0] a,
                                  input logic [11:0] base, input int n);
    in_win = (a >= base) && ({20'h0, a - base} < n);
  endfunction

  localparam int TMR_W_L = lnmon_pkg::TMR_W;

  function automatic logic [TMR_W_L-1:0] resync_len(input logic [7:0] fm1);
    logic [11:0] oct;
    oct = ({4'h0, fm1} + 12'h001) * 12'(lnmon_pkg::RESYNC_FRAMES)
        + 12'(lnmon_pkg::RESYNC_OCTETS + lnmon_pkg::OCTETS_PER_CLK - 1);
    resync_len = TMR_W_L'(oct / 12'(lnmon_pkg::OCTETS_PER_CLK));
  endfunction

  // Registers.
  logic [7:0]  link_ctrl;
  logic [3:0]  pulse_len;
  logic [7:0]  cfg_param [lnmon_pkg::PARAM_BYTES];
  logic [7:0]  error_limit;
  logic [2:0]  sync_assert_select;
  logic [2:0]  lane_en   [NL];
  logic [2:0]  lane_hold [NL];
  logic [7:0]  irq_en;
  logic        mis_en;
  logic [7:0]  irq_st;
  logic        mis_st;
  logic [NL-1:0] lane_group_lock_status;
  logic [NL-1:0] lane_frame_lock_status;
  logic [NL-1:0] lane_checksum_ok_status;
  logic [NL-1:0] lane_alignment_status;
  logic        mis_seen;
  logic [2:0]  disp_run [NL];
  lnmon_pkg::lnmon_sync_e state;
  lnmon_pkg::lnmon_sync_e next_state;
  logic [TMR_W_L-1:0] tmr;
  logic [TMR_W_L-1:0] next_tmr;

  // Counters.
  logic [7:0]    cnt  [NC];
  logic [NC-1:0] hit;
  logic [NC-1:0] term;
  logic [NC-1:0] cnt_clr;
  logic [NL-1:0] csum_match;
  logic [7:0]    csum_calc [NL];
  logic [111:0]  cfg_flat;
  logic [NT-1:0] type_hit;
  logic [NL-1:0] disp4;

  wire resync_now = (state == lnmon_pkg::ST_RESYNC);
  wire wr_lane    = reg_wr && in_win(reg_addr, lnmon_pkg::A_LANE_CTRL, NL);
  wire [2:0] wr_idx = 3'(reg_addr - lnmon_pkg::A_LANE_CTRL);

  genvar gl, gt, gb;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_lane
      wire [NT-1:0] errs = {bad_disparity_error[gl], not_in_table_error[gl],
                            unexpected_control_char_error[gl]};
      for (gt = 0; gt < NT; gt++) begin : g_type
        localparam int K = gl * NT + gt;
        assign cnt_clr[K] = resync_now ||
          (wr_lane && wr_idx == 3'(gl) && !reg_wdata[gt]);
        lnmon_errcnt u_cnt (
          .core_clk (core_clk),
          .rst      (rst),
          .err      (errs[gt]),
          .enable   (lane_en[gl][gt]),
          .hold     (lane_hold[gl][gt]),
          .clear    (cnt_clr[K]),
          .limit    (error_limit),
          .count    (cnt[K]),
          .hit      (hit[K]),
          .terminal (term[K])
        );
      end
      lnmon_csum u_csum (
        .packed_mode (link_ctrl[lnmon_pkg::CSUM_MODE_BIT]),
        .params      (rx_params[103:0]),
        .lane_id     (lane_rx_id[gl*5 +: 5]),
        .checksum    (csum_calc[gl])
      );
      assign csum_match[gl] =
        (csum_calc[gl] == lane_rx_checksum[gl*8 +: 8]);
      assign disp4[gl] = bad_disparity_error[gl] &&
        (disp_run[gl] == 3'(lnmon_pkg::DISP_REINIT_CHARS - 1));
    end
    for (gt = 0; gt < NT; gt++) begin : g_thit
      logic acc;
      always_comb begin
        acc = 1'b0;
        for (int l = 0; l < NL; l++) begin
          acc = acc | hit[l*NT + gt];
        end
      end
      assign type_hit[gt] = acc;
    end
    // A net, not a function, so the compare follows every config write.
    for (gb = 0; gb < lnmon_pkg::PARAM_BYTES; gb++) begin : g_flat
      assign cfg_flat[gb*8 +: 8] = cfg_param[gb];
    end
  endgenerate

  wire sel_hit      = |(type_hit & sync_assert_select);
  wire start_resync = sel_hit || (|disp4);
  wire any_err      = |{unexpected_control_char_error, not_in_table_error,
                        bad_disparity_error};
  // pulse length select; a half cycle rounds up to one.
  wire [TMR_W_L-1:0] pulse_cyc = (pulse_len == lnmon_pkg::PULSE_LEN_F4)
                                 ? TMR_W_L'(1) : TMR_W_L'(0);
  wire [TMR_W_L-1:0] rs_cyc =
    resync_len(cfg_param[lnmon_pkg::CFG_F_BYTE]) - TMR_W_L'(1);

  always_comb begin
    next_state = state;
    next_tmr   = tmr;
    unique case (state)
      lnmon_pkg::ST_LINK_UP, lnmon_pkg::ST_ERR_PULSE: begin
        if (start_resync) begin
          next_state = lnmon_pkg::ST_RESYNC;
          next_tmr   = rs_cyc;
        end else if (state == lnmon_pkg::ST_LINK_UP && any_err) begin
          next_state = lnmon_pkg::ST_ERR_PULSE;
          next_tmr   = pulse_cyc;
        end else if (state == lnmon_pkg::ST_ERR_PULSE) begin
          if (tmr == '0) next_state = lnmon_pkg::ST_LINK_UP;
          else next_tmr = tmr - TMR_W_L'(1);
        end
      end
      lnmon_pkg::ST_RESYNC: begin
        if (tmr == '0) next_state = lnmon_pkg::ST_LINK_UP;
        else next_tmr = tmr - TMR_W_L'(1);
      end
      default: begin
        next_state = lnmon_pkg::ST_LINK_UP;
        next_tmr   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state              <= lnmon_pkg::ST_LINK_UP;
      tmr                <= '0;
      sync_request_out_n <= 1'b1;
    end else begin
      state              <= next_state;
      tmr                <= next_tmr;
      sync_request_out_n <= (next_state == lnmon_pkg::ST_LINK_UP);
    end
  end

  // Disparity run per lane, reset by every resync.
  always_ff @(posedge core_clk) begin
    for (int l = 0; l < NL; l++) begin
      if (rst || resync_now) disp_run[l] <= 3'h0;
      else if (bad_disparity_error[l]) disp_run[l] <= disp_run[l] + 3'h1;
    end
  end

  // Link establishment status and failure events.
  wire [NL-1:0] ilas_rise = lane_ilas_done & ~lane_alignment_status;
  wire [NL-1:0] csum_now  = lane_ilas_done & csum_match;
  wire mismatch = |(cfg_flat ^ rx_params);
  wire mis_evt  = mismatch && (|lane_ilas_done) && !mis_seen;
  wire [7:0] fail_evt = {type_hit,
    1'b0,
    |(lane_alignment_status & ~lane_ilas_done),
    |(ilas_rise & ~csum_match),
    |(lane_frame_lock_status & ~lane_frame_done),
    |(lane_group_lock_status & ~lane_cgs_done)};

  wire wr_irq_st = reg_wr && reg_addr == lnmon_pkg::A_IRQ_ST;
  wire wr_mis_st = reg_wr && reg_addr == lnmon_pkg::A_MIS_ST;
  wire [7:0] irq_clr = wr_irq_st ? reg_wdata : 8'h00;
  wire [7:0] irq_set = fail_evt & irq_en;
  wire [7:0] next_irq_st = (irq_st & ~irq_clr) | irq_set;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lane_group_lock_status  <= '0;
      lane_frame_lock_status  <= '0;
      lane_checksum_ok_status <= '0;
      lane_alignment_status   <= '0;
      irq_st                  <= 8'h00;
      mis_st                  <= 1'b0;
      mis_seen                <= 1'b0;
    end else begin
      lane_group_lock_status  <= lane_cgs_done;
      lane_frame_lock_status  <= lane_frame_done;
      lane_alignment_status   <= lane_ilas_done;
      lane_checksum_ok_status <= csum_now;
      irq_st   <= next_irq_st;
      mis_seen <= mismatch && (|lane_ilas_done);
      mis_st <= (mis_st && !(wr_mis_st && reg_wdata[0]))
                || (mis_evt && mis_en);
    end
  end

  // Register writes.
  wire [3:0] cfg_idx = 4'(reg_addr - lnmon_pkg::A_CFG_PARAM);
  wire [2:0] hold_idx = 3'(reg_addr - lnmon_pkg::A_LANE_HOLD);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_ctrl          <= 8'h00;
      pulse_len          <= lnmon_pkg::PULSE_LEN_RST;
      error_limit        <= lnmon_pkg::ERR_LIMIT_RST;
      sync_assert_select <= lnmon_pkg::SYNC_SEL_RST;
      irq_en             <= lnmon_pkg::IRQ_EN_RST;
      mis_en             <= lnmon_pkg::MIS_EN_RST;
      for (int i = 0; i < lnmon_pkg::PARAM_BYTES; i++) cfg_param[i] <= 8'h00;
      for (int l = 0; l < NL; l++) begin
        lane_en[l]   <= lnmon_pkg::ERR_EN_RST;
        lane_hold[l] <= lnmon_pkg::HOLD_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr == lnmon_pkg::A_LINK_CTRL) link_ctrl <= reg_wdata;
      if (reg_addr == lnmon_pkg::A_SYNC_PULSE)
        pulse_len <= reg_wdata[lnmon_pkg::PULSE_LEN_LSB +: 4];
      if (reg_addr == lnmon_pkg::A_ERR_LIMIT) error_limit <= reg_wdata;
      if (reg_addr == lnmon_pkg::A_SYNC_SEL)
        sync_assert_select <= reg_wdata[2:0];
      if (reg_addr == lnmon_pkg::A_IRQ_EN) irq_en <= reg_wdata;
      if (reg_addr == lnmon_pkg::A_MIS_EN) mis_en <= reg_wdata[0];
      if (in_win(reg_addr, lnmon_pkg::A_CFG_PARAM, lnmon_pkg::PARAM_BYTES))
        cfg_param[cfg_idx] <= reg_wdata;
      if (wr_lane)
        lane_en[wr_idx] <= reg_wdata[lnmon_pkg::ERR_EN_LSB +: 3];
      if (in_win(reg_addr, lnmon_pkg::A_LANE_HOLD, NL))
        lane_hold[hold_idx] <= reg_wdata[2:0];
    end
  end

  // Read selection.
  wire [11:0] ra = reg_addr;
  wire [2:0]  rl = 3'(ra - lnmon_pkg::A_LANE_CTRL);
  wire [2:0]  rt = 3'(ra - lnmon_pkg::A_LANE_TERM);
  wire [4:0]  rc = 5'(ra - lnmon_pkg::A_ERR_CNT);
  wire [3:0]  rp = 4'(ra - lnmon_pkg::A_RX_PARAM);
  wire [7:0]  rd_val =
    ra == lnmon_pkg::A_LINK_CTRL  ? link_ctrl :
    ra == lnmon_pkg::A_SYNC_PULSE ? {pulse_len, 4'h0} :
    in_win(ra, lnmon_pkg::A_RX_PARAM, lnmon_pkg::PARAM_BYTES)
                                  ? rx_params[rp*8 +: 8] :
    in_win(ra, lnmon_pkg::A_CFG_PARAM, lnmon_pkg::PARAM_BYTES)
                                  ? cfg_param[cfg_idx] :
    ra == lnmon_pkg::A_GRP_LOCK   ? 8'(lane_group_lock_status) :
    ra == lnmon_pkg::A_FRAME_LOCK ? 8'(lane_frame_lock_status) :
    ra == lnmon_pkg::A_CSUM_OK    ? 8'(lane_checksum_ok_status) :
    ra == lnmon_pkg::A_ALIGN      ? 8'(lane_alignment_status) :
    ra == lnmon_pkg::A_ERR_LIMIT  ? error_limit :
    ra == lnmon_pkg::A_SYNC_SEL   ? {5'h00, sync_assert_select} :
    in_win(ra, lnmon_pkg::A_LANE_CTRL, NL) ? {2'h0, lane_en[rl], 3'h7} :
    in_win(ra, lnmon_pkg::A_LANE_HOLD, NL) ? {5'h00, lane_hold[hold_idx]} :
    in_win(ra, lnmon_pkg::A_LANE_TERM, NL) ?
      {4'h0, lane_group_lock_status[rt], term[rt*NT +: NT]} :
    ra == lnmon_pkg::A_IRQ_EN     ? irq_en :
    ra == lnmon_pkg::A_MIS_EN     ? {7'h00, mis_en} :
    ra == lnmon_pkg::A_IRQ_ST     ? irq_st :
    ra == lnmon_pkg::A_MIS_ST     ? {7'h00, mis_st} :
    in_win(ra, lnmon_pkg::A_ERR_CNT, lnmon_pkg::CNT_WIN)
      ? cnt[rc[2:0]*NT + rc[4:lnmon_pkg::CNT_TYPE_LSB]] : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_val;
  end

  // Checks.
  sequence s_resync_start;
    state != lnmon_pkg::ST_RESYNC && start_resync;
  endsequence
  property p_err_pulse;
    @(posedge core_clk) disable iff (rst)
    state == lnmon_pkg::ST_LINK_UP && any_err |=> !sync_request_out_n;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("error did not pulse the sync request");
  property p_resync_len;
    @(posedge core_clk) disable iff (rst)
    s_resync_start |=> !sync_request_out_n [*4];
  endproperty
  a_resync_len: assert property (p_resync_len)
    else $error("resync request shorter than minimum");
  property p_disp4;
    @(posedge core_clk) disable iff (rst)
    |disp4 |=> state == lnmon_pkg::ST_RESYNC;
  endproperty
  a_disp4: assert property (p_disp4)
    else $error("fourth disparity error did not resync");
  property p_sel_hit;
    @(posedge core_clk) disable iff (rst)
    sel_hit |=> state == lnmon_pkg::ST_RESYNC && !sync_request_out_n;
  endproperty
  a_sel_hit: assert property (p_sel_hit)
    else $error("selected threshold hit did not drive sync low");
  property p_clear;
    @(posedge core_clk) disable iff (rst)
    resync_now && !wr_irq_st |=> cnt[0] == 8'h00
      && (irq_st & $past(irq_st)) == $past(irq_st);
  endproperty
  a_clear: assert property (p_clear)
    else $error("resync did not clear counter or touched status");
  property p_ovr_irq;
    @(posedge core_clk) disable iff (rst)
    (|(type_hit & irq_en[lnmon_pkg::IRQ_OVR_LSB +: NT])) ##1 !wr_irq_st
    |-> (|irq_st[lnmon_pkg::IRQ_OVR_LSB +: NT]) [*2];
  endproperty
  a_ovr_irq: assert property (p_ovr_irq)
    else $error("over-threshold status not held");
  property p_w1c;
    @(posedge core_clk) disable iff (rst)
    wr_irq_st && reg_wdata[0] && !irq_set[0] |=> !irq_st[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear status");
  property p_mis;
    @(posedge core_clk) disable iff (rst)
    mis_evt && mis_en |=> mis_st;
  endproperty
  a_mis: assert property (p_mis)
    else $error("mismatch status not set");
  property p_limit_rst;
    @(posedge core_clk) $fell(rst)
      |-> error_limit == lnmon_pkg::ERR_LIMIT_RST
      && sync_assert_select == lnmon_pkg::SYNC_SEL_RST;
  endproperty
  a_limit_rst: assert property (p_limit_rst)
    else $error("limit or select reset value wrong");
endmodule

//--- verilog/lnmon_pkg.sv
// Shared constants and types for the receive link error monitor.
package lnmon_pkg;
  localparam int NUM_LANES   = 8;
  localparam int NUM_TYPES   = 3;
  localparam int PARAM_BYTES = 14;
  localparam int CSUM_BYTES  = 13;
  // Register offsets.
  localparam logic [11:0] A_LINK_CTRL  = 12'h300;
  localparam logic [11:0] A_SYNC_PULSE = 12'h312;
  localparam logic [11:0] A_RX_PARAM   = 12'h400;
  localparam logic [11:0] A_CFG_PARAM  = 12'h450;
  localparam logic [11:0] A_GRP_LOCK   = 12'h470;
  localparam logic [11:0] A_FRAME_LOCK = 12'h471;
  localparam logic [11:0] A_CSUM_OK    = 12'h472;
  localparam logic [11:0] A_ALIGN      = 12'h473;
  localparam logic [11:0] A_ERR_LIMIT  = 12'h47C;
  localparam logic [11:0] A_SYNC_SEL   = 12'h47D;
  localparam logic [11:0] A_LANE_CTRL  = 12'h480;
  localparam logic [11:0] A_LANE_HOLD  = 12'h488;
  localparam logic [11:0] A_LANE_TERM  = 12'h490;
  localparam logic [11:0] A_IRQ_EN     = 12'h4B8;
  localparam logic [11:0] A_MIS_EN     = 12'h4B9;
  localparam logic [11:0] A_IRQ_ST     = 12'h4BA;
  localparam logic [11:0] A_MIS_ST     = 12'h4BB;
  localparam logic [11:0] A_ERR_CNT    = 12'h4C0;
  localparam int          CNT_WIN      = 24;
  // Error type index, also the bit order of select, enable and hold.
  localparam int ERR_UEK = 0;
  localparam int ERR_NIT = 1;
  localparam int ERR_BDE = 2;
  // Field positions.
  localparam int CSUM_MODE_BIT  = 6;
  localparam int ERR_EN_LSB     = 3;
  localparam int LANE_ACT_BIT   = 3;
  localparam int IRQ_OVR_LSB    = 5;
  localparam int IRQ_CGS        = 0;
  localparam int IRQ_FRAME      = 1;
  localparam int IRQ_CSUM       = 2;
  localparam int IRQ_ILAS       = 3;
  localparam int PULSE_LEN_LSB  = 4;
  localparam int CFG_F_BYTE     = 4;
  localparam int CNT_TYPE_LSB   = 3;
  // Link parameter byte layout used by the field-sum checksum.
  localparam int B_DID = 0;
  localparam int B_BID = 1;
  localparam int B_SCR_L = 3;
  localparam int B_F = 4;
  localparam int B_K = 5;
  localparam int B_M = 6;
  localparam int B_N = 7;
  localparam int B_SUB_NP = 8;
  localparam int B_JV_S = 9;
  localparam int B_HD = 10;
  localparam logic [7:0] MASK_LO4 = 8'h0F;
  localparam logic [7:0] MASK_LO5 = 8'h1F;
  localparam int TOP3_LSB = 5;
  localparam int TOP_BIT  = 7;
  // Reset values, counter maximum and pulse length codes.
  localparam logic [7:0] ERR_LIMIT_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [2:0] SYNC_SEL_RST  = 3'h7;
  localparam logic [2:0] ERR_EN_RST    = 3'h7;
  localparam logic [2:0] HOLD_RST      = 3'h0;
  localparam logic [7:0] IRQ_EN_RST    = 8'h00;
  localparam logic       MIS_EN_RST    = 1'b1;
  localparam logic [3:0] PULSE_LEN_RST = 4'h0;
  localparam logic [3:0] PULSE_LEN_F2  = 4'h1;
  localparam logic [3:0] PULSE_LEN_F4  = 4'h2;
  // Timing, in frames and octets; the core clock carries four octets.
  localparam int OCTETS_PER_CLK    = 4;
  localparam int RESYNC_FRAMES     = 5;
  localparam int RESYNC_OCTETS     = 9;
  localparam int DISP_REINIT_CHARS = 4;
  localparam int TMR_W             = 9;
  typedef enum logic [1:0] {
    ST_LINK_UP   = 2'b00,
    ST_ERR_PULSE = 2'b01,
    ST_RESYNC    = 2'b10
  } lnmon_sync_e;
endpackage

//--- verilog/lnmon_errcnt.sv
// One error counter for one lane and one error type.
`timescale 1ns/10ps
module lnmon_errcnt (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       err,
  input  wire logic       enable,
  input  wire logic       hold,
  input  wire logic       clear,
  input  wire logic [7:0] limit,
  // Status
  output logic [7:0]      count,
  output logic            hit,
  output logic            terminal
);
  wire       inc        = err & enable & ~clear;
  wire       at_max     = (count == lnmon_pkg::CNT_MAX);
  wire       stalled    = hold & at_max;
  wire [7:0] next_count = count + 8'h01;

  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count    <= 8'h00;
      hit      <= 1'b0;
      terminal <= 1'b0;
    end else begin
      if (inc && !stalled) begin
        count <= next_count;
      end
      hit <= inc && !stalled && (next_count == limit);
      if (inc && !stalled && next_count == lnmon_pkg::CNT_MAX) begin
        terminal <= 1'b1;
      end
    end
  end
endmodule

//--- verilog/lnmon_csum.sv
// Local checksum of the received link parameters for one lane.
`timescale 1ns/10ps
module lnmon_csum (
  // Inputs
  input  wire logic         packed_mode,
  input  wire logic [103:0] params,
  input  wire logic [4:0]   lane_id,
  // Result
  output logic [7:0]        checksum
);
  function automatic logic [7:0] pb(input logic [103:0] p, input int i);
    pb = p[i*8 +: 8];
  endfunction

  logic [7:0] field_sum;
  logic [7:0] packed_sum;

  always_comb begin
    field_sum = pb(params, lnmon_pkg::B_DID)
      + (pb(params, lnmon_pkg::B_BID) & lnmon_pkg::MASK_LO4)
      + {3'h0, lane_id}
      + {7'h00, params[lnmon_pkg::B_SCR_L*8 + lnmon_pkg::TOP_BIT]}
      + (pb(params, lnmon_pkg::B_SCR_L) & lnmon_pkg::MASK_LO5)
      + pb(params, lnmon_pkg::B_F)
      + (pb(params, lnmon_pkg::B_K) & lnmon_pkg::MASK_LO5)
      + pb(params, lnmon_pkg::B_M)
      + (pb(params, lnmon_pkg::B_N) & lnmon_pkg::MASK_LO5)
      + (pb(params, lnmon_pkg::B_SUB_NP) >> lnmon_pkg::TOP3_LSB)
      + (pb(params, lnmon_pkg::B_SUB_NP) & lnmon_pkg::MASK_LO5)
      + (pb(params, lnmon_pkg::B_JV_S) >> lnmon_pkg::TOP3_LSB)
      + (pb(params, lnmon_pkg::B_JV_S) & lnmon_pkg::MASK_LO5)
      + {7'h00, params[lnmon_pkg::B_HD*8 + lnmon_pkg::TOP_BIT]};
    packed_sum = {3'h0, lane_id};
    for (int i = 0; i < lnmon_pkg::CSUM_BYTES; i++) begin
      packed_sum = packed_sum + pb(params, i);
    end
    checksum = packed_mode ? packed_sum : field_sum;
  end
endmodule

//--- bench/lnmon_tx_model.sv
// Transmitter model: lane error pulses, link stage levels, parameters.
`timescale 1ns/10ps
module lnmon_tx_model (
  // Clock
  input  wire logic core_clk,
  // Lane errors, type t lane l at bit 8*t+l
  output logic [23:0]  err,
  // Link establishment
  output logic [7:0]   cgs,
  output logic [7:0]   frame,
  output logic [7:0]   ilas,
  output logic [63:0]  csum,
  output logic [39:0]  lid,
  output logic [111:0] params
);
  // Bytes 0 and 12 at one: lane 0 carries the field sum and lane 1 the
  // packed sum, and both disagree with the all-zero configuration.
  initial begin
    {err, cgs, frame, ilas, lid} = '0;
    params = 112'h0001_0000_0000_0000_0000_0000_0001;
    csum = 64'h0201;
  end
  // One pulse is one bad character; a quiet cycle separates pulses.
  task automatic send(input int t, input int l, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk) err[8*t+l] = 1'b1;
      @(negedge core_clk) err[8*t+l] = 1'b0;
    end
  endtask
  task automatic link(input logic [7:0] c, input logic [7:0] a);
    @(negedge core_clk);
    cgs = c;
    frame = c;
    ilas = a;
  endtask
endmodule

//--- bench/jesd_rx_link_error_monitor_tb.sv
// Self-checking bench for the receive link error monitor.
`timescale 1ns/10ps
module jesd_rx_link_error_monitor_tb;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic [11:0]  addr = 12'h000;
  logic         wr_en = 1'b0;
  logic [7:0]   wdata = 8'h00;
  logic         rd_en = 1'b0;
  logic [7:0]   rdata;
  logic [23:0]  err;
  logic [7:0]   cgs, frame, ilas;
  logic [63:0]  csum;
  logic [39:0]  lid;
  logic [111:0] params;
  logic         sync_n;
  int           n_mismatch = 0;
  int           samples_checked = 0;
  int           len;
  logic [19:0]  rows [8] = '{20'h47CFF, 20'h47D07, 20'h31200, 20'h4873F,
                           20'h4B901, 20'h4B800, 20'h4BA00, 20'h4FF00};
  logic [7:0]   plen [3] = '{8'h00, 8'h10, 8'h20};
  always #25 core_clk = ~core_clk;
  lnmon_tx_model u_tx (.core_clk(core_clk), .err(err), .cgs(cgs),
    .frame(frame), .ilas(ilas), .csum(csum), .lid(lid), .params(params));
  lnmon_monitor DUT (.core_clk(core_clk), .rst(rst), .reg_addr(addr),
    .reg_wr(wr_en), .reg_wdata(wdata), .reg_rd(rd_en), .reg_rdata(rdata),
    .unexpected_control_char_error(err[7:0]),
    .not_in_table_error(err[15:8]), .bad_disparity_error(err[23:16]),
    .lane_cgs_done(cgs), .lane_frame_done(frame), .lane_ilas_done(ilas),
    .lane_rx_checksum(csum), .lane_rx_id(lid), .rx_params(params),
    .sync_request_out_n(sync_n));
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk) {addr, wdata, wr_en} = {a, d, 1'b1};
    @(negedge core_clk) wr_en = 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    @(negedge core_clk) {addr, rd_en} = {a, 1'b1};
    @(negedge core_clk) rd_en = 1'b0;
    @(negedge core_clk) check(rdata, e);
  endtask
  // Counts the low cycles of the next request; a stuck line ends the run.
  task automatic low_len(output int n);
    n = 0;
    // The request starts before the sender returns, so look first.
    for (int i = 0; i < 20; i++) begin
      if (sync_n === 1'b0) n++;
      else if (n > 0) return;
      @(negedge core_clk);
    end
    n_mismatch++;
    summarize();
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    foreach (rows[i]) rdchk(rows[i][19:8], rows[i][7:0]);
    foreach (plen[i]) begin
      wr(12'h312, plen[i]);
      u_tx.send(0, 3, 1);
      low_len(len);
      check(8'(len), (plen[i] == 8'h20) ? 8'h02 : 8'h01);
    end
    wr(12'h312, 8'h00);
    u_tx.send(2, 0, 3);
    repeat (6) @(negedge core_clk);
    u_tx.send(2, 0, 1);
    low_len(len);
    check(8'(len), 8'h04);
    rdchk(12'h4D0, 8'h00);
    rdchk(12'h4C3, 8'h00);
    wr(12'h47C, 8'h02);
    wr(12'h4B8, 8'h20);
    u_tx.send(0, 1, 2);
    repeat (10) @(negedge core_clk);
    rdchk(12'h4BA, 8'h20);
    rdchk(12'h4C1, 8'h00);
    wr(12'h4BA, 8'h20);
    rdchk(12'h4BA, 8'h00);
    wr(12'h47C, 8'hFF);
    wr(12'h47D, 8'h00);
    wr(12'h48A, 8'h02);
    u_tx.send(1, 2, 300);
    rdchk(12'h4CA, 8'hFF);
    rdchk(12'h492, 8'h02);
    rdchk(12'h4BA, 8'h00);
    wr(12'h482, 8'h3D);
    rdchk(12'h4CA, 8'h00);
    rdchk(12'h492, 8'h00);
    wr(12'h4B8, 8'h0F);
    u_tx.link(8'hFF, 8'h03);
    repeat (3) @(negedge core_clk);
    rdchk(12'h470, 8'hFF);
    rdchk(12'h471, 8'hFF);
    rdchk(12'h472, 8'h01);
    rdchk(12'h473, 8'h03);
    rdchk(12'h4BB, 8'h01);
    rdchk(12'h4BA, 8'h04);
    wr(12'h300, 8'h40);
    rdchk(12'h472, 8'h02);
    u_tx.link(8'h00, 8'h00);
    rdchk(12'h4BA, 8'h0F);
    wr(12'h4BA, 8'h0F);
    rdchk(12'h4BA, 8'h00);
    summarize();
  end
endmodule
